/* File: windowed_watchdog_timer_test.sv */
// self-checking bench: bus tasks, oscillator, timeout and window scenarios
// assumes the core model in wwd_core_model.sv drives the core strobes
`timescale 1ns/1ps
`include "wwd_consts.svh"
module windowed_watchdog_timer_test;
    logic        sys_clk, rst_n, low_power_rc_osc_clk_pin, low_power_rc_osc_en, irq;
    logic [4:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rdq;
    logic        clr_instr, power_save_instruction_instr, power_save_instruction_idle, clk_switch_done, wake_exit;
    logic        wdt_wake, wdt_reset_req;
    bit          got_rst, got_wake;
    int          miscompares, checks_done, edges, p, o;
    integer      seed;

    wwd_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .low_power_rc_osc_clk_pin(low_power_rc_osc_clk_pin),
        .low_power_rc_osc_en(low_power_rc_osc_en), .clr_instr(clr_instr), .power_save_instruction_instr(power_save_instruction_instr),
        .power_save_instruction_idle(power_save_instruction_idle), .clk_switch_done(clk_switch_done),
        .wake_exit(wake_exit), .wdt_wake(wdt_wake), .wdt_reset_req(wdt_reset_req),
        .irq(irq));
    wwd_core_model core (.sys_clk(sys_clk), .low_power_rc_osc_clk_pin(low_power_rc_osc_clk_pin),
        .low_power_rc_osc_en(low_power_rc_osc_en), .clr_instr(clr_instr), .power_save_instruction_instr(power_save_instruction_instr),
        .power_save_instruction_idle(power_save_instruction_idle), .clk_switch_done(clk_switch_done),
        .wake_exit(wake_exit));

    always #5 sys_clk = ~sys_clk;
    // oscillator stands still while the watchdog has it disabled
    always begin
        repeat (5) @(posedge sys_clk);
        if (low_power_rc_osc_en === 1'b1) low_power_rc_osc_clk_pin <= ~low_power_rc_osc_clk_pin;
    end
    always @(posedge low_power_rc_osc_clk_pin) edges++;

    function automatic int period(int pre, int post);
        return (pre ? 128 : 32) << post;
    endfunction
    function automatic int wopen(int pp, int code);
        case (code)
            3: return pp - pp / 4;
            2: return pp - pp * 3 / 8;
            1: return pp / 2;
            default: return pp / 4;
        endcase
    endfunction
    function automatic logic [31:0] cfg(int post, int pre, int en, int wd, int win);
        return {22'h0, win[1:0], wd[0], en[1:0], pre[0], post[3:0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50) miscompares++;
        rdq = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdq, exp);
    endtask
    task automatic wait_edges(input int k);
        int n;
        n = 0;
        while (edges < k && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic wait_to(input int lim);
        int n;
        n = 0;
        got_rst = 0;
        got_wake = 0;
        while (n < lim && !got_rst && !got_wake) begin
            @(posedge sys_clk);
            n++;
            got_rst = (wdt_reset_req === 1'b1);
            got_wake = (wdt_wake === 1'b1);
        end
    endtask
    task automatic sync(input int kind);
        core.issue(kind);
        edges = 0;
    endtask
    task automatic close_out;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge sys_clk);
        miscompares++;
        close_out;
    end

    initial begin
        sys_clk = 0; rst_n = 0; low_power_rc_osc_clk_pin = 0; avs_address = 0;
        avs_read = 0; avs_write = 0; avs_writedata = 0; seed = 32'hF4459BAD;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdchk(`WWD_OFF_CFG, 32'h3DF);
        rdchk(`WWD_OFF_RESET_CONTROL_REG, 32'h0);
        rdchk(`WWD_OFF_CNT, 32'h0);
        rdchk(5'h18, 32'h0);
        chk(low_power_rc_osc_en, 1'b0);
        wr(`WWD_OFF_RESET_CONTROL_REG, 32'h20);
        // oscillator enable is registered one cycle behind the enable
        @(posedge sys_clk);
        chk(low_power_rc_osc_en, 1'b1);
        wr(`WWD_OFF_RESET_CONTROL_REG, 32'h0);
        @(posedge sys_clk);
        chk(low_power_rc_osc_en, 1'b0);
        wr(`WWD_OFF_CFG, cfg(0, 0, 3, 1, 0));
        @(posedge sys_clk);
        chk(low_power_rc_osc_en, 1'b1);
        wr(`WWD_OFF_IEN, 32'h6);
        for (int i = 0; i < 4; i++) begin
            p = period($random(seed) & 1, {$random(seed)} % 3);
            o = ($random(seed) & 1) ? 3 : 0;
            wr(`WWD_OFF_CFG, cfg({$random(seed)} % 3, 0, 3, 1, 0));
            wr(`WWD_OFF_CFG, cfg((p >= 128 && p != 128) ? (p == 256 ? 1 : 2) : 0,
                p >= 128 ? 1 : 0, 3, 1, 0));
            if (p == 64) wr(`WWD_OFF_CFG, cfg(1, 0, 3, 1, 0));
            sync(o);
            wait_edges(p / 2);
            sync(o);
            wait_to(p * 12 + 100);
            chk(got_rst, 1'b1);
            chk(edges, p);
            rdchk(`WWD_OFF_RESET_CONTROL_REG, 32'h10);
            chk(irq, i > 0);
            wr(`WWD_OFF_SCLR, 32'h7);
            wr(`WWD_OFF_RESET_CONTROL_REG, 32'h0);
            rdchk(`WWD_OFF_RESET_CONTROL_REG, 32'h0);
            chk(irq, 1'b0);
            wr(`WWD_OFF_IEN, 32'h7);
        end
        wr(`WWD_OFF_CFG, cfg(0, 0, 3, 1, 0));
        sync(1);
        rdchk(`WWD_OFF_RESET_CONTROL_REG, 32'h08);
        wait_to(500);
        chk(got_wake, 1'b1);
        chk(edges, 32);
        rdchk(`WWD_OFF_RESET_CONTROL_REG, 32'h18);
        wr(`WWD_OFF_RESET_CONTROL_REG, 32'h0);
        wr(`WWD_OFF_CFG, cfg(0, 0, 1, 1, 0));
        sync(2);
        wait_to(500);
        chk(got_wake, 1'b1);
        sync(1);
        wait_to(800);
        chk({got_wake, got_rst}, 2'b00);
        chk(low_power_rc_osc_en, 1'b0);
        sync(4);
        wait_to(500);
        chk(got_rst, 1'b1);
        wr(`WWD_OFF_CFG, cfg(0, 0, 0, 1, 0));
        wr(`WWD_OFF_RESET_CONTROL_REG, 32'h20);
        rdchk(`WWD_OFF_RESET_CONTROL_REG, 32'h0);
        for (int c = 0; c < 4; c++) begin
            o = wopen(32, c);
            wr(`WWD_OFF_CFG, cfg(0, 0, 3, 0, c));
            sync(3);
            wr(`WWD_OFF_SCLR, 32'h7);
            wait_edges(o - 1);
            sync(0);
            wait_to(20);
            chk(got_rst, 1'b1);
            rdchk(`WWD_OFF_STAT, 32'h4);
            wr(`WWD_OFF_SCLR, 32'h7);
            wait_edges(o);
            sync(0);
            wait_to(20);
            chk(got_rst, 1'b0);
        end
        wr(`WWD_OFF_CFG, cfg(0, 0, 2, 1, 0));
        wr(`WWD_OFF_RESET_CONTROL_REG, 32'h20);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdchk(`WWD_OFF_RESET_CONTROL_REG, 32'h0);
        rdchk(`WWD_OFF_CFG, 32'h3DF);
        rdchk(`WWD_OFF_CNT, 32'h0);
        close_out;
    end
endmodule

/* File: wwd_cnt_if.sv */
// control and status between the watchdog top and its counter
// assumes both ends on sys_clk
`timescale 1ns/1ps
`include "wwd_consts.svh"
interface wwd_cnt_if;
    logic                   tick;
    logic                   clear;
    logic                   run;
    logic                   pre;
    logic [3:0]             post;
    logic [1:0]             win;
    logic [`WWD_CNT_W-1:0]  count;
    logic                   expire;
    logic                   win_open;
    modport ctl (output tick, clear, run, pre, post, win, input count, expire, win_open);
    modport cnt (input tick, clear, run, pre, post, win, output count, expire, win_open);
endinterface

/* File: wwd_consts.svh */
// offsets, field positions, reset values and widths of the watchdog
// assumes inclusion by bare name before any module that uses it
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH
`define WWD_OFF_CFG     5'h00
`define WWD_OFF_RESET_CONTROL_REG    5'h04
`define WWD_OFF_STAT    5'h08
`define WWD_OFF_SCLR    5'h0C
`define WWD_OFF_IEN     5'h10
`define WWD_OFF_CNT     5'h14
`define WWD_CFG_RST     10'h3DF
`define WWD_RESET_CONTROL_REG_RST    6'h00
`define WWD_RESET_CONTROL_REG_WMASK  6'h3C
`define WWD_IEN_RST     3'h0
`define WWD_POST_LSB    0
`define WWD_PRE_BIT     4
`define WWD_EN_LSB      5
`define WWD_WINDOW_DISABLE_BIT  7
`define WWD_WIN_LSB     8
`define WWD_IDLE_BIT    2
`define WWD_SLEEP_BIT   3
`define WWD_TO_BIT      4
`define WWD_SWEN_BIT    5
`define WWD_PRE_SH_LO   5'h05
`define WWD_PRE_SH_HI   5'h07
`define WWD_CNT_W       23
`endif

/* File: wwd_core_model.sv */
// processor core model: issues clear, power-save, clock-switch and wake strobes
// assumes the bench oscillator runs while low_power_rc_osc_en is high
`timescale 1ns/1ps
module wwd_core_model (
    // clock and oscillator
    input  wire logic sys_clk,
    input  wire logic low_power_rc_osc_clk_pin,
    input  wire logic low_power_rc_osc_en,
    // strobes to the watchdog
    output logic      clr_instr,
    output logic      power_save_instruction_instr,
    output logic      power_save_instruction_idle,
    output logic      clk_switch_done,
    output logic      wake_exit
);
    initial begin
        clr_instr       = 1'b0;
        power_save_instruction_instr    = 1'b0;
        power_save_instruction_idle     = 1'b0;
        clk_switch_done = 1'b0;
        wake_exit       = 1'b0;
    end
    // kind: 0 clear, 1 sleep, 2 idle, 3 clock switch done, 4 wake by other source
    task automatic issue(input int kind);
        // strobe mid oscillator period so the bench edge count stays exact
        if (low_power_rc_osc_en) begin
            @(negedge low_power_rc_osc_clk_pin);
        end
        @(posedge sys_clk);
        clr_instr       <= (kind == 0);
        power_save_instruction_instr    <= (kind == 1 || kind == 2);
        power_save_instruction_idle     <= (kind == 2);
        clk_switch_done <= (kind == 3);
        wake_exit       <= (kind == 4);
        @(posedge sys_clk);
        clr_instr       <= 1'b0;
        power_save_instruction_instr    <= 1'b0;
        power_save_instruction_idle     <= 1'b0;
        clk_switch_done <= 1'b0;
        wake_exit       <= 1'b0;
    endtask
endmodule

/* File: wwd_counter.sv */
// prescaler, postscaler and window decode as one tick counter
// assumes tick is a one-cycle pulse per oscillator period
`timescale 1ns/1ps
`include "wwd_consts.svh"
module wwd_counter (
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    // control from top
    wwd_cnt_if.cnt     cb
);
    logic [`WWD_CNT_W-1:0] lim;
    logic [`WWD_CNT_W-1:0] win_start;
    logic [4:0]            shift;
    logic                  last;

    function automatic logic [`WWD_CNT_W-1:0] open_at(input logic [`WWD_CNT_W-1:0] l,
                                                      input logic [1:0] w);
        case (w)
            2'h3:    open_at = l - (l >> 2);
            2'h2:    open_at = l - (l >> 2) - (l >> 3);
            2'h1:    open_at = l >> 1;
            default: open_at = l >> 2;
        endcase
    endfunction

    // one count spans prescaler and postscaler: period = pre * 2^post ticks
    assign shift     = (cb.pre ? `WWD_PRE_SH_HI : `WWD_PRE_SH_LO) + {1'b0, cb.post};
    assign lim       = `WWD_CNT_W'(1) << shift;
    assign win_start = open_at(lim, cb.win);
    assign last      = cb.run & cb.tick & (cb.count >= lim - `WWD_CNT_W'(1));
    assign cb.win_open = cb.count >= win_start;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cb.count  <= '0;
            cb.expire <= 1'b0;
        end else begin
            cb.expire <= last & ~cb.clear;
            if (cb.clear || last)
                cb.count <= '0;
            else if (cb.run && cb.tick)
                cb.count <= cb.count + `WWD_CNT_W'(1);
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_prescale_short: assert property ((!cb.pre && cb.post == 4'h0) |-> lim == 23'h20)
        else $error("short prescale period wrong");
    a_postscale_max: assert property ((cb.pre && cb.post == 4'hF) |-> lim == 23'h400000)
        else $error("longest period wrong");
    a_expire_point: assert property ((cb.run && cb.tick && !cb.clear
        && cb.count == lim - 23'h1) |=> (cb.expire && cb.count == '0))
        else $error("expiry not at end of period");
endmodule

/* File: wwd_pkg.sv */
// types shared by the watchdog modules
// assumes nothing beyond a SystemVerilog compiler
package wwd_pkg;
    typedef enum logic [2:0] {
        WWD_RUN   = 3'h1,
        WWD_SLEEP = 3'h2,
        WWD_IDLE  = 3'h4
    } wwd_state_e;
    typedef enum logic [1:0] {
        WWD_EN_OFF = 2'h0,
        WWD_EN_ACT = 2'h1,
        WWD_EN_SW  = 2'h2,
        WWD_EN_ON  = 2'h3
    } wwd_en_e;
endpackage

/* File: wwd_top.sv */
// windowed watchdog: Avalon-MM registers, power state, timeout actions
// assumes core strobes are one-cycle pulses on sys_clk; oscillator pin is async
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "wwd_consts.svh"
module wwd_top
    import wwd_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // oscillator
    input  wire logic        low_power_rc_osc_clk_pin,
    output logic             low_power_rc_osc_en,
    // processor core
    input  wire logic        clr_instr,
    input  wire logic        power_save_instruction_instr,
    input  wire logic        power_save_instruction_idle,
    input  wire logic        clk_switch_done,
    input  wire logic        wake_exit,
    output logic             wdt_wake,
    output logic             wdt_reset_req,
    output logic             irq
);
    wwd_cnt_if cnt_bus ();

    logic [9:0]  cfg;
    logic [5:0]  reset_control_reg;
    logic [2:0]  status;
    logic [2:0]  irq_en;
    wwd_state_e  state;
    wwd_state_e  next_state;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // bus decode
    wire        wr       = avs_write & ~avs_waitrequest;
    wire        wr_cfg   = wr & (avs_address == `WWD_OFF_CFG);
    wire        wr_reset_control_reg  = wr & (avs_address == `WWD_OFF_RESET_CONTROL_REG);
    wire        wr_sclr  = wr & (avs_address == `WWD_OFF_SCLR);
    wire        wr_ien   = wr & (avs_address == `WWD_OFF_IEN);
    wire [31:0] cfg_w    = merge({22'h0, cfg}, avs_writedata, avs_byteenable);
    wire [31:0] reset_control_reg_m   = merge({26'h0, reset_control_reg}, avs_writedata, avs_byteenable);
    wire [31:0] ien_m    = merge({29'h0, irq_en}, avs_writedata, avs_byteenable);
    wire [31:0] sclr_m   = merge(32'h0, avs_writedata, avs_byteenable);
    wire [31:0] rd_mux   =
        (avs_address == `WWD_OFF_CFG)  ? {22'h0, cfg} :
        (avs_address == `WWD_OFF_RESET_CONTROL_REG) ? {26'h0, reset_control_reg} :
        (avs_address == `WWD_OFF_STAT) ? {29'h0, status} :
        (avs_address == `WWD_OFF_IEN)  ? {29'h0, irq_en} :
        (avs_address == `WWD_OFF_CNT)  ? {9'h0, cnt_bus.count} : 32'h0;

    // watchdog control
    wwd_en_e en_field;
    assign en_field = wwd_en_e'(cfg[`WWD_EN_LSB +: 2]);
    wire in_run    = (state == WWD_RUN);
    wire soft_en   = reset_control_reg[`WWD_SWEN_BIT];
    wire active    = (en_field == WWD_EN_ON)
                   | ((en_field == WWD_EN_SW) & soft_en)
                   | ((en_field == WWD_EN_ACT) & (state != WWD_SLEEP));
    wire expire    = cnt_bus.expire;
    wire to_run    = expire & in_run;
    wire to_low    = expire & ~in_run;
    wire exit_low  = ~in_run & (wake_exit | expire);
    wire clr_run   = clr_instr & in_run;
    wire enter_low = power_save_instruction_instr & in_run;
    wire windowed  = ~cfg[`WWD_WINDOW_DISABLE_BIT];
    // clearing before the window opens counts as a missed service
    wire early     = clr_run & active & windowed & ~cnt_bus.win_open;

    assign cnt_bus.tick  = osc_s2 & ~osc_s3;
    assign cnt_bus.run   = active;
    assign cnt_bus.pre   = cfg[`WWD_PRE_BIT];
    assign cnt_bus.post  = cfg[`WWD_POST_LSB +: 4];
    assign cnt_bus.win   = cfg[`WWD_WIN_LSB +: 2];
    // a disabled watchdog holds at zero so enabling starts a full period
    assign cnt_bus.clear = ~active
                         | clr_run
                         | enter_low
                         | exit_low
                         | clk_switch_done;

    wire [5:0] hw_set = {1'b0,
                         expire,
                         enter_low & ~power_save_instruction_idle,
                         enter_low & power_save_instruction_idle,
                         2'h0};
    wire [5:0] reset_control_reg_w = wr_reset_control_reg ? (reset_control_reg_m[5:0] & `WWD_RESET_CONTROL_REG_WMASK) : reset_control_reg;
    wire [5:0] swen_kill = {en_field == WWD_EN_OFF, 5'h0};
    // hardware sets win over a same-cycle software clear
    wire [5:0] next_reset_control_reg   = (reset_control_reg_w | hw_set) & ~swen_kill;
    wire [2:0] events      = {early, to_low, expire};
    wire [2:0] next_status = (status & ~(wr_sclr ? sclr_m[2:0] : 3'h0)) | events;
    wire [2:0] next_ien    = wr_ien ? ien_m[2:0] : irq_en;

    always_comb begin
        case (state)
            WWD_RUN:   next_state = enter_low ? (power_save_instruction_idle ? WWD_IDLE : WWD_SLEEP) : WWD_RUN;
            WWD_SLEEP: next_state = exit_low ? WWD_RUN : WWD_SLEEP;
            WWD_IDLE:  next_state = exit_low ? WWD_RUN : WWD_IDLE;
            default:   next_state = WWD_RUN;
        endcase
    end

    // oscillator pin is asynchronous: two stages, then the edge stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= low_power_rc_osc_clk_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // each access answers on the second cycle of the request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg    <= `WWD_CFG_RST;
            reset_control_reg   <= `WWD_RESET_CONTROL_REG_RST;
            status <= 3'h0;
            irq_en <= `WWD_IEN_RST;
            state  <= WWD_RUN;
        end else begin
            cfg    <= wr_cfg ? cfg_w[9:0] : cfg;
            reset_control_reg   <= next_reset_control_reg;
            status <= next_status;
            irq_en <= next_ien;
            state  <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_power_rc_osc_en       <= 1'b0;
            wdt_wake      <= 1'b0;
            wdt_reset_req <= 1'b0;
            irq           <= 1'b0;
        end else begin
            low_power_rc_osc_en       <= active;
            wdt_wake      <= to_low;
            wdt_reset_req <= to_run | early;
            irq           <= |(next_status & next_ien);
        end
    end

    wwd_counter u_counter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cb      (cnt_bus)
    );

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cleared;
        cnt_bus.count == '0;
    endsequence
    sequence s_low_timeout;
        expire && !in_run;
    endsequence
    sequence s_woken;
        wdt_wake && in_run ##1 !wdt_wake;
    endsequence

    a_osc_follows: assert property (active |=> low_power_rc_osc_en)
        else $error("oscillator enable not following watchdog");
    a_osc_off: assert property (!active |=> !low_power_rc_osc_en)
        else $error("oscillator left enabled");
    a_switch_clears: assert property (clk_switch_done |=> s_cleared)
        else $error("clock switch did not clear count");
    a_power_save_instruction_clears: assert property (enter_low |=> (s_cleared and !in_run))
        else $error("power save did not clear count");
    a_exit_clears: assert property ((!in_run && wake_exit) |=> (s_cleared and in_run))
        else $error("exit from low power did not clear count");
    a_clr_clears: assert property (clr_run |=> s_cleared)
        else $error("clear instruction ignored");
    a_sleep_wake: assert property (s_low_timeout |=> s_woken)
        else $error("timeout in low power did not wake");
    a_forced_on: assert property ((en_field == WWD_EN_ON) |-> active)
        else $error("forced watchdog not running");
    a_soft_only: assert property ((en_field == WWD_EN_SW) |-> (active == soft_en))
        else $error("soft enable not steering watchdog");
    a_field_off: assert property ((en_field == WWD_EN_OFF) |-> !active ##1 !soft_en)
        else $error("disabled watchdog still active");
    a_flag_sticky: assert property ((reset_control_reg[`WWD_TO_BIT] && !wr_reset_control_reg) |=> reset_control_reg[`WWD_TO_BIT])
        else $error("timeout flag lost");
    a_flag_set: assert property (expire |=> reset_control_reg[`WWD_TO_BIT] && status[0])
        else $error("timeout flag not set");
    a_reset_req: assert property (to_run |=> (wdt_reset_req ##1 !wdt_reset_req))
        else $error("run timeout without reset request");
    a_window_early: assert property (early |=> (wdt_reset_req && status[2]))
        else $error("early clear not reported");
endmodule
